/* eerd_cfg.svh */
/*
 * constants of the two-wire eeprom read block: bus patterns, size defaults, write time.
 * assumes it is included by bare name before the package and the design modules.
 */
`ifndef EERD_CFG_SVH
`define EERD_CFG_SVH

// fixed four-bit type pattern at the top of the device address word
`define EERD_TYPE_ID 4'hA
// bits in every address or data word
`define EERD_WORD_BITS 4'h8
// last bit index of a shifted-out byte
`define EERD_LAST_BIT 4'h7
// number of strapped select pins
`define EERD_SEL_BITS 3
// default memory depth in bytes and page size in bytes
`define EERD_DEPTH_DEF 2048
`define EERD_PAGE_DEF 16
// self-timed write time in ms, and the system clock rate in Hz
`define EERD_WR_TIME_MS 5
`define EERD_SYS_HZ 10000000
// cycles of the self-timed write, rounded down as a longest time
`define EERD_WR_CYCLES ((`EERD_WR_TIME_MS * `EERD_SYS_HZ) / 1000)

`endif

/* eerd_pkg.sv */
/*
 * types shared by the eeprom read block: link-side states and pin bundles.
 * assumes eerd_cfg.svh is on the include path.
 */
`include "eerd_cfg.svh"

package eerd_pkg;

    // protocol states of the link-side engine, one-hot
    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_DEV   = 9'h002,
        ST_DACK  = 9'h004,
        ST_WORD  = 9'h008,
        ST_WACK  = 9'h010,
        ST_WDAT  = 9'h020,
        ST_DTACK = 9'h040,
        ST_RD    = 9'h080,
        ST_MACK  = 9'h100
    } eerd_state_t;

    // pins as sampled from the bus
    typedef struct packed {
        logic scl;
        logic sda;
        logic [`EERD_SEL_BITS-1:0] sel;
    } eerd_pins_t;

    // everything that enters the link domain from outside it
    typedef struct packed {
        logic rst;
        logic busy;
        eerd_pins_t pins;
    } eerd_link_in_t;

endpackage : eerd_pkg

/* eerd_sync2.sv */
/*
 * two-flop level synchroniser for a bundle of bits.
 * assumes every input bit is a slowly changing level seen from the destination clock.
 */
module eerd_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first flop feeds only the second
    always_ff @(posedge clk_i) begin
        meta_ff <= d_i;
        sync_ff <= meta_ff;
    end

    assign q_o = sync_ff;

endmodule : eerd_sync2

/* eerd_pulse_xing.sv */
/*
 * carries a one-cycle event from one clock domain to another by a toggle.
 * assumes events in the source are spaced by several destination cycles.
 */
module eerd_pulse_xing (
    input wire logic src_clk_i,
    input wire logic src_rst_i,
    input wire logic pulse_i,
    input wire logic dst_clk_i,
    input wire logic dst_rst_i,
    output logic pulse_o
);

    logic tgl_ff;
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // source side flips on each event
    always_ff @(posedge src_clk_i) begin
        if (src_rst_i) begin
            tgl_ff <= 1'b0;
        end else if (pulse_i) begin
            tgl_ff <= ~tgl_ff;
        end
    end

    // destination side synchronises and detects a change
    always_ff @(posedge dst_clk_i) begin
        if (dst_rst_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= tgl_ff;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign pulse_o = sync_ff ^ prev_ff;

endmodule : eerd_pulse_xing

/* eerd_top.sv */
/*
 * two-wire serial eeprom slave: device addressing, read forms, address counter,
 * page-wrapped byte storing and the self-timed write busy window.
 * assumes link_clk_i samples scl/sda several times per bus bit; sda is open drain.
 */
// What this block does
// - while the self-timed write runs, the device address is not acknowledged.
// - read starts like a write but with direction bit one.
// - current-address, random and sequential reads are served.
// - address counter holds last accessed address plus one.
// - address counter keeps its value between transfers until reset.
// - read increment past the last byte wraps to address zero.
// - write increment wraps inside the current page, upper bits kept.
// - after a read device address is acknowledged, byte at counter shifts out.
// - repeated start, read address, one byte, no acknowledge, stop.
// - sequential read starts from either read form, controller acknowledges bytes.
// - each controller acknowledge advances the address and shifts the next byte.
// - missing acknowledge then stop ends the read; device releases data.
// - sda fall with scl high is start, rise with scl high is stop.
// - words are eight bits; receiver drives low acknowledge on ninth clock.
// - device address is type pattern, three select or page bits, direction.
// - on address mismatch no acknowledge and return to idle.
`include "eerd_cfg.svh"

module eerd_top
    import eerd_pkg::*;
#(
    parameter int DEPTH = `EERD_DEPTH_DEF,
    parameter int PAGE = `EERD_PAGE_DEF,
    parameter int WR_CYCLES = `EERD_WR_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic select_pin_low_i,
    input wire logic select_pin_mid_i,
    input wire logic select_pin_high_i,
    output logic write_busy_o
);

    localparam int AW = $clog2(DEPTH);
    localparam int PW = $clog2(PAGE);
    localparam int UB = (AW > 8) ? (AW - 8) : 0;
    // select bits that are compared; the rest are page bits
    localparam logic [2:0] SEL_MASK = 3'(3'h7 << UB);

    // system domain: self-timed write window
    logic [31:0] wr_cnt_ff;
    logic busy_ff;
    logic wr_done_sys;

    // link domain
    eerd_link_in_t link_in;
    eerd_link_in_t link_s;
    logic rst_link;
    logic busy_s;
    logic scl_q_ff;
    logic sda_q_ff;
    eerd_state_t st_ff;
    logic [3:0] cnt_ff;
    logic [7:0] sh_ff;
    logic rw_ff;
    logic [2:0] page_ff;
    logic mack_ff;
    logic drv_low_ff;
    logic wrote_ff;
    logic [AW-1:0] addr_ff;
    logic [7:0] mem [DEPTH];
    logic start_c;
    logic stop_c;
    logic scl_rise;
    logic scl_fall;
    logic dev_match;
    logic load_rd;
    logic store_wr;
    logic [10:0] full_addr;
    logic [7:0] rd_byte;

    // pins, reset and busy enter the link domain through two flops
    assign link_in.rst = rst_i;
    assign link_in.busy = busy_ff;
    assign link_in.pins.scl = scl_i;
    assign link_in.pins.sda = sda_i;
    assign link_in.pins.sel = {select_pin_high_i, select_pin_mid_i, select_pin_low_i};

    eerd_sync2 #(
        .WIDTH($bits(eerd_link_in_t))
    ) u_sync (
        .clk_i(link_clk_i),
        .d_i(link_in),
        .q_o(link_s)
    );

    assign rst_link = link_s.rst;
    assign busy_s = link_s.busy;

    // end of a write transfer is handed to the system domain
    eerd_pulse_xing u_wr_done (
        .src_clk_i(link_clk_i),
        .src_rst_i(rst_link),
        .pulse_i(stop_c & wrote_ff),
        .dst_clk_i(sys_clk_i),
        .dst_rst_i(rst_i),
        .pulse_o(wr_done_sys)
    );

    // write-cycle timer counts the self-timed write
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_cnt_ff <= 32'h0000_0000;
            busy_ff <= 1'b0;
        end else if (wr_done_sys) begin
            wr_cnt_ff <= 32'(WR_CYCLES);
            busy_ff <= 1'b1;
        end else if (wr_cnt_ff != 32'h0000_0000) begin
            wr_cnt_ff <= wr_cnt_ff - 32'h0000_0001;
            busy_ff <= (wr_cnt_ff != 32'h0000_0001);
        end
    end

    assign write_busy_o = busy_ff;

    // previous sampled line levels for edge and condition detection
    always_ff @(posedge link_clk_i) begin
        if (rst_link) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= link_s.pins.scl;
            sda_q_ff <= link_s.pins.sda;
        end
    end

    // start and stop are sda edges while scl stays high
    assign start_c = link_s.pins.scl & scl_q_ff & sda_q_ff & ~link_s.pins.sda;
    assign stop_c = link_s.pins.scl & scl_q_ff & ~sda_q_ff & link_s.pins.sda;
    assign scl_rise = link_s.pins.scl & ~scl_q_ff;
    assign scl_fall = ~link_s.pins.scl & scl_q_ff;

    // type pattern and unmasked select bits must match
    assign dev_match = (sh_ff[7:4] == `EERD_TYPE_ID)
        && (((sh_ff[3:1] ^ link_s.pins.sel) & SEL_MASK) == 3'h0);

    // page bits form the top of the loaded word address
    assign full_addr = {page_ff, sh_ff};
    assign rd_byte = mem[addr_ff];
    assign load_rd = scl_fall && (((st_ff == ST_DACK) && rw_ff)
        || ((st_ff == ST_MACK) && mack_ff));
    assign store_wr = scl_fall && (st_ff == ST_WDAT) && (cnt_ff == `EERD_WORD_BITS);

    // protocol state sequencing
    always_ff @(posedge link_clk_i) begin
        if (rst_link) begin
            st_ff <= ST_IDLE;
        end else if (start_c) begin
            st_ff <= ST_DEV;
        end else if (stop_c) begin
            st_ff <= ST_IDLE;
        end else if (scl_fall) begin
            unique case (st_ff)
                ST_IDLE: st_ff <= ST_IDLE;
                ST_DEV: begin
                    if (cnt_ff == `EERD_WORD_BITS) begin
                        // no ack while busy or on mismatch
                        st_ff <= (dev_match && !busy_s) ? ST_DACK : ST_IDLE;
                    end
                end
                ST_DACK: st_ff <= rw_ff ? ST_RD : ST_WORD;
                ST_WORD: begin
                    if (cnt_ff == `EERD_WORD_BITS) begin
                        st_ff <= ST_WACK;
                    end
                end
                ST_WACK: st_ff <= ST_WDAT;
                ST_WDAT: begin
                    if (cnt_ff == `EERD_WORD_BITS) begin
                        st_ff <= ST_DTACK;
                    end
                end
                ST_DTACK: st_ff <= ST_WDAT;
                ST_RD: begin
                    if (cnt_ff == `EERD_LAST_BIT) begin
                        st_ff <= ST_MACK;
                    end
                end
                ST_MACK: st_ff <= mack_ff ? ST_RD : ST_IDLE;
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    // bit counter and shift register
    always_ff @(posedge link_clk_i) begin
        if (rst_link || start_c) begin
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
        end else if (load_rd) begin
            cnt_ff <= 4'h0;
            sh_ff <= rd_byte;
        end else if (scl_rise && (st_ff inside {ST_DEV, ST_WORD, ST_WDAT})) begin
            cnt_ff <= cnt_ff + 4'h1;
            sh_ff <= {sh_ff[6:0], link_s.pins.sda};
        end else if (scl_fall && (st_ff == ST_RD)) begin
            cnt_ff <= cnt_ff + 4'h1;
            sh_ff <= {sh_ff[6:0], 1'b0};
        end else if (scl_fall && (st_ff inside {ST_DACK, ST_WACK, ST_DTACK})) begin
            cnt_ff <= 4'h0;
        end
    end

    // direction and page bits caught from the device address
    always_ff @(posedge link_clk_i) begin
        if (rst_link) begin
            rw_ff <= 1'b0;
            page_ff <= 3'h0;
        end else if (scl_fall && (st_ff == ST_DEV) && (cnt_ff == `EERD_WORD_BITS)) begin
            rw_ff <= sh_ff[0];
            page_ff <= sh_ff[3:1];
        end
    end

    // controller acknowledge sampled on the ninth rising clock
    always_ff @(posedge link_clk_i) begin
        if (rst_link) begin
            mack_ff <= 1'b0;
        end else if (scl_rise && (st_ff == ST_MACK)) begin
            mack_ff <= ~link_s.pins.sda;
        end
    end

    // open-drain data driver: ack slots and read bits, changed on scl low
    always_ff @(posedge link_clk_i) begin
        if (rst_link || start_c || stop_c) begin
            drv_low_ff <= 1'b0;
        end else if (load_rd) begin
            drv_low_ff <= ~rd_byte[7];
        end else if (scl_fall) begin
            unique case (st_ff)
                ST_DEV: drv_low_ff <= (cnt_ff == `EERD_WORD_BITS) && dev_match && !busy_s;
                ST_WORD: drv_low_ff <= (cnt_ff == `EERD_WORD_BITS);
                ST_WDAT: drv_low_ff <= (cnt_ff == `EERD_WORD_BITS);
                ST_RD: drv_low_ff <= (cnt_ff != `EERD_LAST_BIT) && ~sh_ff[6];
                default: drv_low_ff <= 1'b0;
            endcase
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = drv_low_ff;

    // word address counter, reset only with the device
    always_ff @(posedge link_clk_i) begin
        if (rst_link) begin
            addr_ff <= '0;
        end else if (scl_fall && (st_ff == ST_WORD) && (cnt_ff == `EERD_WORD_BITS)) begin
            addr_ff <= full_addr[AW-1:0];
        end else if (load_rd) begin
            addr_ff <= addr_ff + AW'(1);
        end else if (store_wr) begin
            // only the in-page bits advance on a write
            addr_ff[PW-1:0] <= addr_ff[PW-1:0] + PW'(1);
        end
    end

    // byte storing for received data words
    always_ff @(posedge link_clk_i) begin
        if (store_wr) begin
            mem[addr_ff] <= sh_ff;
        end
    end

    // remembers that this transfer stored data, to start the write cycle
    always_ff @(posedge link_clk_i) begin
        if (rst_link || start_c || stop_c) begin
            wrote_ff <= 1'b0;
        end else if (store_wr) begin
            wrote_ff <= 1'b1;
        end
    end

    property p_busy_noack;
        @(posedge link_clk_i) disable iff (rst_link)
        (scl_fall && !start_c && !stop_c && (st_ff == ST_DEV) && (cnt_ff == `EERD_WORD_BITS)
            && busy_s) |=> (st_ff == ST_IDLE) && !sda_oe_o;
    endproperty
    a_busy_noack: assert property (p_busy_noack) else $error("ack given while busy");

    property p_mismatch_idle;
        @(posedge link_clk_i) disable iff (rst_link)
        (scl_fall && !start_c && !stop_c && (st_ff == ST_DEV) && (cnt_ff == `EERD_WORD_BITS)
            && !dev_match) |=> (st_ff == ST_IDLE);
    endproperty
    a_mismatch_idle: assert property (p_mismatch_idle) else $error("mismatch not idle");

    property p_read_starts;
        @(posedge link_clk_i) disable iff (rst_link)
        (load_rd && !start_c && !stop_c) |=> (st_ff == ST_RD) && (sda_oe_o == ~sh_ff[7]);
    endproperty
    a_read_starts: assert property (p_read_starts) else $error("read byte not driven");

    property p_read_inc;
        @(posedge link_clk_i) disable iff (rst_link)
        load_rd |=> (addr_ff == $past(addr_ff) + AW'(1));
    endproperty
    a_read_inc: assert property (p_read_inc) else $error("read address not advanced");

    property p_read_wrap;
        @(posedge link_clk_i) disable iff (rst_link)
        (load_rd && (addr_ff == {AW{1'b1}})) |=> (addr_ff == '0);
    endproperty
    a_read_wrap: assert property (p_read_wrap) else $error("read wrap wrong");

    property p_write_wrap;
        @(posedge link_clk_i) disable iff (rst_link)
        (store_wr && (addr_ff[PW-1:0] == {PW{1'b1}})) |=> (addr_ff[PW-1:0] == '0)
            && (addr_ff[AW-1:PW] == $past(addr_ff[AW-1:PW]));
    endproperty
    a_write_wrap: assert property (p_write_wrap) else $error("page wrap wrong");

    property p_ack_slot;
        @(posedge link_clk_i) disable iff (rst_link)
        (st_ff inside {ST_DACK, ST_WACK, ST_DTACK}) && !$past(start_c) |-> sda_oe_o;
    endproperty
    a_ack_slot: assert property (p_ack_slot) else $error("ack slot not low");

    property p_nack_ends;
        @(posedge link_clk_i) disable iff (rst_link)
        (scl_fall && (st_ff == ST_MACK) && !mack_ff && !start_c) |=> !sda_oe_o ##1 !sda_oe_o;
    endproperty
    a_nack_ends: assert property (p_nack_ends) else $error("data driven after nack");

    property p_stop_idle;
        @(posedge link_clk_i) disable iff (rst_link)
        stop_c |=> (st_ff == ST_IDLE) && !sda_oe_o;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

endmodule : eerd_top

/* eerd_ctrl_model.sv */
/*
 * two-wire bus controller model: start, stop, byte send and byte receive.
 * assumes the bench resolves sda with a pull-up and calls one task at a time.
 */
module eerd_ctrl_model #(
    parameter int QC = 5
) (
    input wire logic sys_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // bus idle: scl high, sda released
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // one quarter of a bus bit
    task automatic q();
        repeat (QC) @(posedge sys_clk_i);
    endtask : q

    // start or repeated start, sda falls while scl high
    task automatic start();
        scl_o <= 1'b0;
        q();
        sda_low_o <= 1'b0;
        q();
        scl_o <= 1'b1;
        q();
        sda_low_o <= 1'b1;
        q();
        scl_o <= 1'b0;
        q();
    endtask : start

    // stop, sda rises while scl high
    task automatic stop();
        sda_low_o <= 1'b1;
        q();
        scl_o <= 1'b1;
        q();
        sda_low_o <= 1'b0;
        q();
    endtask : stop

    // eight bits msb first, then sample the ninth-clock acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low_o <= ~b[i];
            q();
            scl_o <= 1'b1;
            q();
            q();
            scl_o <= 1'b0;
            q();
        end
        sda_low_o <= 1'b0;
        q();
        scl_o <= 1'b1;
        q();
        ack = ~sda_i;
        q();
        scl_o <= 1'b0;
        q();
    endtask : send_byte

    // eight bits sampled on scl high, then acknowledge low or withheld
    task automatic recv_byte(input logic ack_low, output logic [7:0] d);
        sda_low_o <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            q();
            scl_o <= 1'b1;
            q();
            d[i] = sda_i;
            q();
            scl_o <= 1'b0;
        end
        q();
        sda_low_o <= ack_low;
        q();
        scl_o <= 1'b1;
        q();
        q();
        scl_o <= 1'b0;
        q();
    endtask : recv_byte
endmodule : eerd_ctrl_model

/* eerd_top_bench.sv */
/*
 * self-checking bench for the eeprom read block: writes, polling, all read forms.
 * assumes eerd_ctrl_model drives the bus and sda has a pull-up.
 */
module eerd_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import eerd_pkg::*;

    localparam logic [2:0] SEL = 3'h5;
    localparam logic [6:0] DEV = {4'hA, SEL};
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic scl;
    logic ctrl_low;
    logic sda_out;
    logic sda_oe;
    logic busy;
    logic sda_wire;
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    // open-drain wire with pull-up
    assign sda_wire = ~(ctrl_low | (sda_oe & ~sda_out));

    // write window spans two polls of about 205 cycles each, well clear of both edges
    eerd_top #(.DEPTH(256), .PAGE(16), .WR_CYCLES(500)) i_eerd_top (
        .sys_clk_i(sys_clk), .rst_i(rst), .link_clk_i(link_clk), .scl_i(scl),
        .sda_i(sda_wire), .sda_o(sda_out), .sda_oe_o(sda_oe),
        .select_pin_low_i(SEL[0]), .select_pin_mid_i(SEL[1]),
        .select_pin_high_i(SEL[2]), .write_busy_o(busy)
    );

    eerd_ctrl_model #(.QC(5)) i_eerd_ctrl_model (
        .sys_clk_i(sys_clk), .sda_i(sda_wire), .scl_o(scl), .sda_low_o(ctrl_low)
    );

    // clocks, link clock unrelated in phase
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        #17;
        forever #32 link_clk = ~link_clk;
    end

    task automatic print_verdict();
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // start plus device address until acknowledged, counting attempts
    task automatic dev_poll(input logic rw, output int n);
        logic ack;
        n = 0;
        do begin
            i_eerd_ctrl_model.start();
            i_eerd_ctrl_model.send_byte({DEV, rw}, ack);
            n++;
        end while (ack !== 1'b1 && n < 60);
        check({7'h0, ack}, 8'h01);
    endtask : dev_poll

    // write n bytes from word w; busy_exp says whether polls were refused
    task automatic t_write(input logic [7:0] w, input logic [7:0] d[3], input int n,
            input logic busy_exp);
        logic ack;
        int polls;
        dev_poll(1'b0, polls);
        check({7'h0, polls > 1}, {7'h0, busy_exp});
        i_eerd_ctrl_model.send_byte(w, ack);
        check({7'h0, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            i_eerd_ctrl_model.send_byte(d[i], ack);
            check({7'h0, ack}, 8'h01);
        end
        i_eerd_ctrl_model.stop();
        repeat (20) @(posedge sys_clk);
        // sample away from the edge that updates the busy flop
        @(negedge sys_clk);
        check({7'h0, busy}, 8'h01);
        @(posedge sys_clk);
    endtask : t_write

    // dummy write of word w, repeated start, read n bytes with acks between
    task automatic t_rand_read(input logic [7:0] w, input logic [7:0] e[3], input int n);
        logic ack;
        logic [7:0] d;
        int polls;
        dev_poll(1'b0, polls);
        i_eerd_ctrl_model.send_byte(w, ack);
        check({7'h0, ack}, 8'h01);
        i_eerd_ctrl_model.start();
        i_eerd_ctrl_model.send_byte({DEV, 1'b1}, ack);
        check({7'h0, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            i_eerd_ctrl_model.recv_byte(i < n - 1, d);
            check(d, e[i]);
        end
        i_eerd_ctrl_model.stop();
        check({7'h0, sda_oe}, 8'h00);
    endtask : t_rand_read

    // current-address read picks up after the last access
    task automatic t_cur_read(input logic [7:0] e);
        logic [7:0] d;
        int polls;
        dev_poll(1'b1, polls);
        i_eerd_ctrl_model.recv_byte(1'b0, d);
        check(d, e);
        i_eerd_ctrl_model.stop();
        check({7'h0, sda_oe}, 8'h00);
    endtask : t_cur_read

    // wrong select bits, then wrong type pattern, both refused
    task automatic t_mismatch();
        logic ack;
        i_eerd_ctrl_model.start();
        i_eerd_ctrl_model.send_byte({4'hA, 3'h4, 1'b1}, ack);
        check({7'h0, ack}, 8'h00);
        i_eerd_ctrl_model.start();
        i_eerd_ctrl_model.send_byte({4'hB, SEL, 1'b1}, ack);
        check({7'h0, ack}, 8'h00);
        i_eerd_ctrl_model.stop();
        check({7'h0, sda_oe}, 8'h00);
    endtask : t_mismatch

    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails++;
            print_verdict();
        end
    end

    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        check({5'h0, sda_out, sda_oe, busy}, 8'h00);
        @(posedge sys_clk);
        t_write(8'hFF, '{8'hA5, 8'h3C, 8'h5A}, 3, 1'b0);
        t_write(8'h00, '{8'h96, 8'h00, 8'h00}, 1, 1'b1);
        t_rand_read(8'hF0, '{8'h3C, 8'h00, 8'h00}, 1);
        t_cur_read(8'h5A);
        t_mismatch();
        t_rand_read(8'hFF, '{8'hA5, 8'h96, 8'h00}, 2);
        print_verdict();
    end
endmodule : eerd_top_bench
